//--- logic/adcsc_clkgen.sv
`include "adcsc_defines.svh"

module adcsc_clkgen (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// control
	input wire logic run,
	input wire logic [2:0] clk_sel,
	input wire logic rc_tick,
	// conversion bit period strobe
	output logic tad_tick
);

	adcsc_pkg::adcsc_clk_state_t st_ff;
	adcsc_pkg::adcsc_clk_state_t nxt_st;

	// terminal count for divide by 2, 4 .. 64
	function automatic logic [5:0] div_last(input logic [2:0] sel);
		logic [6:0] div;
		div = 7'h02 << sel;
		div_last = 6'(div - 7'h01);
	endfunction : div_last

	always_comb begin
		nxt_st = st_ff;
		nxt_st.tick = 1'b0;
		if (!run) begin
			// preload one so the first period matches the later ones
			nxt_st.cnt = 6'h01;
		end else if (clk_sel >= `ADCSC_CLK_RC) begin
			nxt_st.cnt = 6'h00;
			nxt_st.tick = rc_tick;
		end else if (st_ff.cnt >= div_last(clk_sel)) begin
			nxt_st.cnt = 6'h00;
			nxt_st.tick = 1'b1;
		end else begin
			nxt_st.cnt = 6'(st_ff.cnt + 6'h01);
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign tad_tick = st_ff.tick;

endmodule : adcsc_clkgen

//--- logic/adcsc_defines.svh
`ifndef ADCSC_DEFINES_SVH
`define ADCSC_DEFINES_SVH

// register byte offsets
`define ADCSC_OFF_CONFIG 8'h00
`define ADCSC_OFF_CTRL 8'h04
`define ADCSC_OFF_CHAN 8'h08
`define ADCSC_OFF_PINS 8'h0C
`define ADCSC_OFF_PRESET 8'h10
`define ADCSC_OFF_RESULT 8'h14
`define ADCSC_OFF_RES_LO 8'h18
`define ADCSC_OFF_RES_HI 8'h1C
`define ADCSC_OFF_STATUS 8'h20
`define ADCSC_OFF_MASK 8'h24

// configure word fields
`define ADCSC_CFG_CLK_LSB 0
`define ADCSC_CFG_JUST_BIT 3
`define ADCSC_CFG_ACQ_LSB 4
`define ADCSC_CFG_VREF_LSB 7
`define ADCSC_CFG_CHAN_LSB 9
`define ADCSC_CFG_PINS_LSB 13

// command bits of the control and channel words
`define ADCSC_CTRL_START_BIT 0
`define ADCSC_CTRL_SHUT_BIT 1
`define ADCSC_CTRL_IRQ_ON_BIT 2
`define ADCSC_CTRL_IRQ_OFF_BIT 3
`define ADCSC_CHAN_GO_BIT 4

// power-on values
`define ADCSC_RST_CLK_SEL 3'h0
`define ADCSC_RST_ACQ 3'h0
`define ADCSC_RST_VREF 2'h0
`define ADCSC_RST_CHAN 4'h0
`define ADCSC_RST_PINS 13'h0000

// encodings and sizes
`define ADCSC_CLK_RC 3'h6
`define ADCSC_CH_CHARGE 4'hD
`define ADCSC_CH_CORE 4'hE
`define ADCSC_CH_BANDGAP 4'hF
`define ADCSC_RES_BITS 10
`define ADCSC_PIN_COUNT 13
`define ADCSC_PRESET_MAX 4'hC

`endif

//--- logic/adcsc_pkg.sv
`include "adcsc_defines.svh"

package adcsc_pkg;

	typedef enum logic [1:0] {
		SAR_IDLE,
		SAR_ACQ,
		SAR_CONV
	} adcsc_sar_state_t;

	// software configuration loaded by a configure write
	typedef struct packed {
		logic [2:0] clk_sel;
		logic just;
		logic [2:0] acq;
		logic [1:0] vref;
	} adcsc_cfg_t;

	// steering toward the input multiplexer and reference switches
	typedef struct packed {
		logic [3:0] channel;
		logic charge_timer_channel;
		logic core_supply_channel;
		logic bandgap_channel;
		logic [`ADCSC_PIN_COUNT-1:0] analog_pins;
		logic vref_pos_ext;
		logic vref_neg_ext;
		logic enable;
	} adcsc_mux_t;

	typedef struct packed {
		logic [5:0] cnt;
		logic tick;
	} adcsc_clk_state_t;

	typedef struct packed {
		adcsc_sar_state_t state;
		logic [4:0] cnt;
		logic [3:0] bit_idx;
		logic [`ADCSC_RES_BITS-1:0] code;
		logic [`ADCSC_RES_BITS-1:0] result;
	} adcsc_sar_regs_t;

	typedef struct packed {
		adcsc_cfg_t cfg;
		logic [3:0] channel;
		logic [`ADCSC_PIN_COUNT-1:0] pins;
		logic on;
		logic gate;
		logic irq_en;
		logic done;
		logic [31:0] prdata;
	} adcsc_regs_t;

endpackage : adcsc_pkg

//--- logic/adcsc_sar.sv
`include "adcsc_defines.svh"

module adcsc_sar (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// sequencing
	input wire logic start,
	input wire logic abort,
	input wire logic tad_tick,
	input wire logic [2:0] acq_sel,
	// converter core
	input wire logic cmp_high,
	output logic sampling,
	output logic [`ADCSC_RES_BITS-1:0] dac_code,
	// status
	output logic busy,
	output logic done,
	output logic [`ADCSC_RES_BITS-1:0] result
);

	adcsc_pkg::adcsc_sar_regs_t st_ff;
	adcsc_pkg::adcsc_sar_regs_t nxt_st;
	logic [`ADCSC_RES_BITS-1:0] kept;

	function automatic logic [4:0] acq_tads(input logic [2:0] sel);
		unique case (sel)
			3'h0: acq_tads = 5'h00;
			3'h1: acq_tads = 5'h02;
			3'h2: acq_tads = 5'h04;
			3'h3: acq_tads = 5'h06;
			3'h4: acq_tads = 5'h08;
			3'h5: acq_tads = 5'h0C;
			3'h6: acq_tads = 5'h10;
			3'h7: acq_tads = 5'h14;
		endcase
	endfunction : acq_tads

	localparam logic [`ADCSC_RES_BITS-1:0] TOP_BIT = {1'b1, {(`ADCSC_RES_BITS-1){1'b0}}};

	always_comb begin
		nxt_st = st_ff;
		done = 1'b0;
		kept = cmp_high ? st_ff.code : (st_ff.code & ~(10'h001 << st_ff.bit_idx));
		if (abort) begin
			nxt_st.state = adcsc_pkg::SAR_IDLE;
		end else begin
			unique case (st_ff.state)
				adcsc_pkg::SAR_IDLE: begin
					// a start while running never reaches here
					if (start) begin
						nxt_st.cnt = acq_tads(acq_sel);
						nxt_st.code = TOP_BIT;
						nxt_st.bit_idx = 4'(`ADCSC_RES_BITS - 1);
						nxt_st.state = (acq_tads(acq_sel) == 5'h00) ? adcsc_pkg::SAR_CONV
							: adcsc_pkg::SAR_ACQ;
					end
				end
				adcsc_pkg::SAR_ACQ: begin
					if (tad_tick) begin
						nxt_st.cnt = 5'(st_ff.cnt - 5'h01);
						if (st_ff.cnt == 5'h01) begin
							nxt_st.state = adcsc_pkg::SAR_CONV;
						end
					end
				end
				adcsc_pkg::SAR_CONV: begin
					if (tad_tick) begin
						if (st_ff.bit_idx == 4'h0) begin
							nxt_st.result = kept;
							nxt_st.state = adcsc_pkg::SAR_IDLE;
							done = 1'b1;
						end else begin
							nxt_st.bit_idx = 4'(st_ff.bit_idx - 4'h1);
							nxt_st.code = kept | (10'h001 << (st_ff.bit_idx - 4'h1));
						end
					end
				end
				default: begin
					nxt_st.state = adcsc_pkg::SAR_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign busy = (st_ff.state != adcsc_pkg::SAR_IDLE);
	assign sampling = (st_ff.state == adcsc_pkg::SAR_ACQ);
	assign dac_code = st_ff.code;
	assign result = st_ff.result;

endmodule : adcsc_sar

//--- logic/adcsc_top.sv
// Functional notes
// - busy reads one while converting, else zero
// - shutdown disables converter and its interrupt
// - start converts once, result pair, completion signalled
// - configure restores power-on values except the gate, then loads fields
// - clock: oscillator divided 2..64, or RC
// - justification: low-aligned ten bits or high-aligned
// - acquisition 0,2,4,6,8,12,16,20 bit periods
// - channel field routes one of sixteen inputs
// - channels 13,14,15 select internal sources
// - thirteen pins individually analogue or digital
// - preset makes first N pins analogue
// - positive and negative reference chosen independently
// - select-and-start writes channel, then starts
// - interrupt enable sets gate and converter enable
// - interrupt disable clears converter enable only
// - result word is ten bits, justified
//
// Design decisions made here: register access over APB and the register addresses.
`include "adcsc_defines.svh"

module adcsc_top (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// dedicated rc oscillator strobe
	input wire logic rc_tick,
	// converter core
	input wire logic cmp_high,
	output logic sampling,
	output logic [`ADCSC_RES_BITS-1:0] dac_code,
	output adcsc_pkg::adcsc_mux_t mux,
	// interrupt
	output logic irq
);

	adcsc_pkg::adcsc_regs_t st_ff;
	adcsc_pkg::adcsc_regs_t nxt_st;
	adcsc_pkg::adcsc_regs_t por;

	logic setup;
	logic wr;
	logic mapped;
	logic wr_config;
	logic wr_ctrl;
	logic wr_chan;
	logic wr_pins;
	logic wr_preset;
	logic wr_status;
	logic wr_mask;
	logic start_cmd;
	logic shut_cmd;
	logic tad_tick;
	logic busy;
	logic done;
	logic [`ADCSC_RES_BITS-1:0] raw;
	logic [15:0] word;
	logic [31:0] rdata;

	// ten-bit value into a sixteen bit word
	function automatic logic [15:0] justify(input logic [`ADCSC_RES_BITS-1:0] r,
		input logic high);
		if (high) begin
			justify = {r, 6'h00};
		end else begin
			justify = {6'h00, r};
		end
	endfunction : justify

	function automatic logic [`ADCSC_PIN_COUNT-1:0] first_pins(input logic [3:0] n);
		logic [`ADCSC_PIN_COUNT:0] ones;
		ones = (14'h0001 << n) - 14'h0001;
		first_pins = ones[`ADCSC_PIN_COUNT-1:0];
	endfunction : first_pins

	function automatic logic is_mapped(input logic [7:0] a);
		unique case (a)
			`ADCSC_OFF_CONFIG, `ADCSC_OFF_CTRL, `ADCSC_OFF_CHAN, `ADCSC_OFF_PINS,
			`ADCSC_OFF_PRESET, `ADCSC_OFF_RESULT, `ADCSC_OFF_RES_LO,
			`ADCSC_OFF_RES_HI, `ADCSC_OFF_STATUS, `ADCSC_OFF_MASK: is_mapped = 1'b1;
			default: is_mapped = 1'b0;
		endcase
	endfunction : is_mapped

	// bus decode
	assign setup = psel & ~penable;
	assign mapped = is_mapped(paddr);
	assign pready = 1'b1;
	assign pslverr = psel & penable & ~mapped;
	assign wr = psel & penable & pwrite & mapped & (&pstrb);
	assign wr_config = wr & (paddr == `ADCSC_OFF_CONFIG);
	assign wr_ctrl = wr & (paddr == `ADCSC_OFF_CTRL);
	assign wr_chan = wr & (paddr == `ADCSC_OFF_CHAN);
	assign wr_pins = wr & (paddr == `ADCSC_OFF_PINS);
	assign wr_preset = wr & (paddr == `ADCSC_OFF_PRESET);
	assign wr_status = wr & (paddr == `ADCSC_OFF_STATUS);
	assign wr_mask = wr & (paddr == `ADCSC_OFF_MASK);

	// conversion commands
	assign shut_cmd = wr_ctrl & pwdata[`ADCSC_CTRL_SHUT_BIT];
	assign start_cmd = st_ff.on & ~shut_cmd & ~wr_config &
		((wr_ctrl & pwdata[`ADCSC_CTRL_START_BIT]) |
		(wr_chan & pwdata[`ADCSC_CHAN_GO_BIT]));

	adcsc_clkgen u_clkgen (
		.pclk(pclk),
		.presetn(presetn),
		.run(busy),
		.clk_sel(st_ff.cfg.clk_sel),
		.rc_tick(rc_tick),
		.tad_tick(tad_tick)
	);

	adcsc_sar u_sar (
		.pclk(pclk),
		.presetn(presetn),
		.start(start_cmd),
		.abort(shut_cmd | wr_config | ~st_ff.on),
		.tad_tick(tad_tick),
		.acq_sel(st_ff.cfg.acq),
		.cmp_high(cmp_high),
		.sampling(sampling),
		.dac_code(dac_code),
		.busy(busy),
		.done(done),
		.result(raw)
	);

	assign word = justify(raw, st_ff.cfg.just);

	// read mux, sampled in the setup cycle
	always_comb begin
		rdata = 32'h00000000;
		unique case (paddr)
			`ADCSC_OFF_CONFIG: begin
				rdata[`ADCSC_CFG_CLK_LSB +: 3] = st_ff.cfg.clk_sel;
				rdata[`ADCSC_CFG_JUST_BIT] = st_ff.cfg.just;
				rdata[`ADCSC_CFG_ACQ_LSB +: 3] = st_ff.cfg.acq;
				rdata[`ADCSC_CFG_VREF_LSB +: 2] = st_ff.cfg.vref;
				rdata[`ADCSC_CFG_CHAN_LSB +: 4] = st_ff.channel;
				rdata[`ADCSC_CFG_PINS_LSB +: `ADCSC_PIN_COUNT] = st_ff.pins;
			end
			`ADCSC_OFF_CTRL: begin
				rdata[0] = busy;
				rdata[1] = st_ff.on;
				rdata[2] = st_ff.gate;
				rdata[3] = st_ff.irq_en;
			end
			`ADCSC_OFF_CHAN: begin
				rdata[3:0] = st_ff.channel;
			end
			`ADCSC_OFF_PINS: begin
				rdata[`ADCSC_PIN_COUNT-1:0] = st_ff.pins;
			end
			`ADCSC_OFF_RESULT: begin
				rdata[15:0] = word;
			end
			`ADCSC_OFF_RES_LO: begin
				rdata[7:0] = word[7:0];
			end
			`ADCSC_OFF_RES_HI: begin
				rdata[7:0] = word[15:8];
			end
			`ADCSC_OFF_STATUS: begin
				rdata[0] = st_ff.done;
			end
			`ADCSC_OFF_MASK: begin
				rdata[0] = st_ff.irq_en;
			end
			default: begin
				rdata = 32'h00000000;
			end
		endcase
	end

	// power-on image of the converter registers
	always_comb begin
		por = '0;
		por.cfg.clk_sel = `ADCSC_RST_CLK_SEL;
		por.cfg.acq = `ADCSC_RST_ACQ;
		por.cfg.vref = `ADCSC_RST_VREF;
		por.channel = `ADCSC_RST_CHAN;
		por.pins = `ADCSC_RST_PINS;
	end

	always_comb begin
		nxt_st = st_ff;
		if (setup) begin
			nxt_st.prdata = rdata;
		end
		if (wr_config) begin
			// everything back to power-on, peripheral gate and read data kept
			nxt_st = por;
			nxt_st.gate = st_ff.gate;
			nxt_st.prdata = st_ff.prdata;
			nxt_st.cfg.clk_sel = pwdata[`ADCSC_CFG_CLK_LSB +: 3];
			nxt_st.cfg.just = pwdata[`ADCSC_CFG_JUST_BIT];
			nxt_st.cfg.acq = pwdata[`ADCSC_CFG_ACQ_LSB +: 3];
			nxt_st.cfg.vref = pwdata[`ADCSC_CFG_VREF_LSB +: 2];
			nxt_st.channel = pwdata[`ADCSC_CFG_CHAN_LSB +: 4];
			nxt_st.pins = pwdata[`ADCSC_CFG_PINS_LSB +: `ADCSC_PIN_COUNT];
			nxt_st.on = 1'b1;
		end
		if (wr_ctrl) begin
			if (pwdata[`ADCSC_CTRL_IRQ_ON_BIT]) begin
				nxt_st.gate = 1'b1;
				nxt_st.irq_en = 1'b1;
			end
			if (pwdata[`ADCSC_CTRL_IRQ_OFF_BIT]) begin
				nxt_st.irq_en = 1'b0;
			end
			if (pwdata[`ADCSC_CTRL_SHUT_BIT]) begin
				nxt_st.on = 1'b0;
				nxt_st.irq_en = 1'b0;
			end
		end
		if (wr_chan) begin
			// takes effect before the start it may carry
			nxt_st.channel = pwdata[3:0];
		end
		if (wr_pins) begin
			nxt_st.pins = pwdata[`ADCSC_PIN_COUNT-1:0];
		end
		if (wr_preset && (pwdata[3:0] <= `ADCSC_PRESET_MAX) && (pwdata[31:4] == 28'h0000000)) begin
			nxt_st.pins = first_pins(pwdata[3:0]);
		end
		if (wr_mask) begin
			nxt_st.irq_en = pwdata[0];
		end
		if (wr_status && pwdata[0]) begin
			nxt_st.done = 1'b0;
		end
		// a completion in the clearing cycle still lands
		if (done) begin
			nxt_st.done = 1'b1;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end

	// multiplexer and reference steering
	always_comb begin
		mux = '0;
		mux.channel = st_ff.channel;
		mux.charge_timer_channel = (st_ff.channel == `ADCSC_CH_CHARGE);
		mux.core_supply_channel = (st_ff.channel == `ADCSC_CH_CORE);
		mux.bandgap_channel = (st_ff.channel == `ADCSC_CH_BANDGAP);
		mux.analog_pins = st_ff.pins;
		mux.vref_pos_ext = st_ff.cfg.vref[1];
		mux.vref_neg_ext = st_ff.cfg.vref[0];
		mux.enable = st_ff.on;
	end

	assign prdata = st_ff.prdata;
	assign irq = st_ff.done & st_ff.irq_en & st_ff.gate & st_ff.on;

endmodule : adcsc_top

//--- test/adc_sequencing_control_tb.sv
`include "adcsc_defines.svh"

module adc_sequencing_control_tb;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [7:0] a_ctl = `ADCSC_OFF_CTRL;
	localparam logic [7:0] a_st = `ADCSC_OFF_STATUS;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, rc_tick, cmp_high, sampling, irq;
	logic e;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, q, cfg, w;
	logic [3:0] pstrb, ch;
	logic [9:0] dac_code;
	adcsc_pkg::adcsc_mux_t mux;
	int err_total = 0;
	int n_compared = 0;
	int samp_cnt = 0;
	int s0, p, a;
	int tad[8] = '{0, 2, 4, 6, 8, 12, 16, 20};
	adcsc_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .rc_tick(rc_tick), .cmp_high(cmp_high),
		.sampling(sampling), .dac_code(dac_code), .mux(mux), .irq(irq));
	adcsc_core_model u_core (.pclk(pclk), .presetn(presetn), .dac_code(dac_code), .mux(mux),
		.cmp_high(cmp_high), .rc_tick(rc_tick));
	initial begin
		pclk = 1'b0;
		forever #2 pclk = ~pclk;
	end
	always @(posedge pclk) samp_cnt <= samp_cnt + int'(sampling === 1'b1);
	task automatic give_verdict;
		$display("compared %0d, mismatches %0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : give_verdict
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			err_total++;
			$display("ERROR %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic xfer(input logic wt, input logic [7:0] ad, input logic [31:0] d);
		int k;
		k = 0;
		psel <= 1'b1;
		pwrite <= wt;
		paddr <= ad;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			k++;
		end while (pready !== 1'b1 && k < 50);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
		if (k >= 50) begin
			err_total++;
			$display("ERROR %0t: no ready", $time);
			give_verdict();
		end
	endtask : xfer
	task automatic wr(input logic [7:0] ad, input logic [31:0] d);
		xfer(1'b1, ad, d);
	endtask : wr
	task automatic rd(input logic [7:0] ad, input logic [31:0] exp);
		xfer(1'b0, ad, 32'h0);
		chk(q, exp);
	endtask : rd
	task automatic wait_idle;
		int k;
		k = 0;
		do begin
			xfer(1'b0, a_ctl, 32'h0);
			k++;
		end while (q[0] !== 1'b0 && k < 2000);
		if (k >= 2000) begin
			err_total++;
			$display("ERROR %0t: conversion hang", $time);
			give_verdict();
		end
	endtask : wait_idle
	initial begin
		{presetn, psel, penable, pwrite, paddr, pwdata} = '0;
		pstrb = 4'hF;
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		rd(`ADCSC_OFF_CONFIG, 32'h0);
		rd(a_ctl, 32'h0);
		chk({31'h0, e}, 32'h0);
		rd(8'h30, 32'h0);
		chk({31'h0, e}, 32'h1);
		$display("test reset done");
		for (int s = 0; s <= 6; s++) begin
			a = (s == 6) ? 0 : s + 2;
			ch = 4'(2 * s + 3);
			p = (s == 6) ? 0 : (2 << s);
			cfg = {6'h00, 13'(s * 37 + 1), ch, 2'(s), 3'(a), 1'(s), 3'(s)};
			w = s[0] ? {16'h0, ch, 12'h540} : {22'h0, ch, 6'h15};
			wr(`ADCSC_OFF_CONFIG, cfg);
			rd(`ADCSC_OFF_CONFIG, cfg);
			rd(a_ctl, 32'h2);
			s0 = samp_cnt;
			wr(a_ctl, 32'h1);
			rd(a_ctl, 32'h3);
			wr(a_ctl, 32'h1);
			wait_idle();
			chk(32'(samp_cnt - s0), 32'(tad[a] * p));
			rd(`ADCSC_OFF_RESULT, w);
			rd(`ADCSC_OFF_RES_LO, {24'h0, w[7:0]});
			rd(`ADCSC_OFF_RES_HI, {24'h0, w[15:8]});
			rd(a_st, 32'h1);
			wr(a_st, 32'h1);
			rd(a_st, 32'h0);
		end
		$display("test conversions done");
		wr(a_ctl, 32'h4);
		rd(a_ctl, 32'hE);
		rd(`ADCSC_OFF_MASK, 32'h1);
		wr(`ADCSC_OFF_CHAN, 32'h1E);
		wait_idle();
		chk({31'h0, irq}, 32'h1);
		rd(`ADCSC_OFF_CHAN, 32'hE);
		rd(`ADCSC_OFF_RESULT, 32'h395);
		wr(a_st, 32'h1);
		chk({31'h0, irq}, 32'h0);
		wr(a_ctl, 32'h8);
		rd(a_ctl, 32'h6);
		wr(a_ctl, 32'h1);
		wait_idle();
		chk({31'h0, irq}, 32'h0);
		rd(a_st, 32'h1);
		$display("test interrupts done");
		wr(a_st, 32'h1);
		wr(a_ctl, 32'h4);
		wr(a_ctl, 32'h1);
		wr(a_ctl, 32'h2);
		rd(a_ctl, 32'h4);
		wr(a_ctl, 32'h1);
		rd(a_ctl, 32'h4);
		rd(a_st, 32'h0);
		chk({31'h0, irq}, 32'h0);
		$display("test shutdown done");
		for (int n = 0; n <= 13; n++) begin
			wr(`ADCSC_OFF_PINS, 32'h0AAA);
			wr(`ADCSC_OFF_PRESET, 32'(n));
			rd(`ADCSC_OFF_PINS, (n > 12) ? 32'h0AAA : (32'h1 << n) - 32'h1);
		end
		$display("test presets done");
		give_verdict();
	end
endmodule : adc_sequencing_control_tb

//--- test/adcsc_core_model.sv
module adcsc_core_model (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// from the block
	input wire logic [9:0] dac_code,
	input wire adcsc_pkg::adcsc_mux_t mux,
	// to the block
	output logic cmp_high,
	output logic rc_tick
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [2:0] rc_cnt;
	// each channel carries a fixed level made from its number
	assign cmp_high = {mux.channel, 6'h15} >= dac_code;
	// rc oscillator strobe every fifth cycle
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rc_cnt <= 3'h0;
			rc_tick <= 1'b0;
		end else begin
			rc_cnt <= (rc_cnt == 3'h4) ? 3'h0 : rc_cnt + 3'h1;
			rc_tick <= rc_cnt == 3'h4;
		end
	end
endmodule : adcsc_core_model

//--- test/adcsc_properties.sv
`include "adcsc_defines.svh"

module adcsc_properties (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	// converter side
	input wire logic rc_tick,
	input wire logic cmp_high,
	input wire logic sampling,
	input wire logic [`ADCSC_RES_BITS-1:0] dac_code,
	input wire adcsc_pkg::adcsc_mux_t mux,
	input wire logic irq
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	logic wr;
	assign wr = psel && penable && pwrite && pstrb == 4'hF;
	chan_flags_a: assert property ({mux.charge_timer_channel, mux.core_supply_channel,
		mux.bandgap_channel} == {mux.channel == `ADCSC_CH_CHARGE,
		mux.channel == `ADCSC_CH_CORE, mux.channel == `ADCSC_CH_BANDGAP})
		else $error("internal source flags disagree with channel");
	shutdown_off_a: assert property (wr && paddr == `ADCSC_OFF_CTRL && pwdata[1]
		|=> !mux.enable && !irq) else $error("shutdown left converter or irq active");
	configure_load_a: assert property (wr && paddr == `ADCSC_OFF_CONFIG |=> mux.enable
		&& !irq && mux.channel == $past(pwdata[12:9]))
		else $error("configure did not load channel or enable");
	pins_load_a: assert property (wr && paddr == `ADCSC_OFF_CONFIG
		|=> mux.analog_pins == $past(pwdata[25:13])) else $error("pin field not loaded");
	vref_load_a: assert property (wr && paddr == `ADCSC_OFF_CONFIG
		|=> {mux.vref_pos_ext, mux.vref_neg_ext} == $past(pwdata[8:7]))
		else $error("reference selection not loaded");
	preset_pins_a: assert property (wr && paddr == `ADCSC_OFF_PRESET && pwdata <= 32'h0000000C
		|=> mux.analog_pins == (13'h0001 << $past(pwdata[3:0])) - 13'h0001)
		else $error("preset did not make first pins analogue");
	irq_off_a: assert property (wr && paddr == `ADCSC_OFF_CTRL && pwdata[3] |=> !irq)
		else $error("irq stayed high after disable");
	chan_write_a: assert property (wr && paddr == `ADCSC_OFF_CHAN
		|=> mux.channel == $past(pwdata[3:0])) else $error("channel write not routed");
	irq_needs_on_a: assert property ($rose(irq) |-> mux.enable)
		else $error("irq raised while converter off");
	cover property (wr && paddr == `ADCSC_OFF_CTRL && pwdata[0]);
	cover property ($rose(irq));
	cover property (wr && paddr == `ADCSC_OFF_CHAN && pwdata[4]);
endmodule : adcsc_properties

bind adcsc_top adcsc_properties u_props (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
	.prdata(prdata), .pready(pready), .pslverr(pslverr), .rc_tick(rc_tick),
	.cmp_high(cmp_high), .sampling(sampling), .dac_code(dac_code), .mux(mux), .irq(irq));
